// ### dv/dio_pad_model.sv
// pad-side partner model: drives the pad inputs on both tile clock edges
`timescale 1ns/1ps
`default_nettype none

module dio_pad_model (
  input  wire logic io_clk,
  input  wire logic rise_bit,
  input  wire logic fall_bit,
  input  wire logic n_bit,
  output logic      pad_in_p,
  output logic      pad_in_n
);

  // ****************************************************
  // new bit ahead of every clock transition
  // ****************************************************
  // changing at the opposite edge keeps each bit stable around its sample
  always @(io_clk) begin
    pad_in_p <= io_clk ? fall_bit : rise_bit;
    pad_in_n <= n_bit;
  end
endmodule
`default_nettype wire

// ### dv/dio_tile_tb_top.sv
// self-checking bench for the i/o tile
`timescale 1ns/1ps
`default_nettype none
`include "dio_defs.svh"
`define CHK(g, e, m) begin n_tests++; if ((g) !== (e)) begin error_cnt++; \
  $display("wrong value at %0t: %s", $time, m); end end

module dio_tile_tb_top;
  logic        clk = 1'b0;
  logic        io_clk = 1'b0;
  logic        resetn = 1'b0;
  logic [3:0]  addr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [31:0] rdata;
  logic        register_clear = 1'b1;
  logic        core_out_rise = 1'b0;
  logic        core_out_fall = 1'b0;
  logic        core_oe = 1'b0;
  logic        core_out_en = 1'b1;
  logic        core_in_en = 1'b1;
  logic        core_in_rise;
  logic        core_in_fall;
  logic        pad_in_p;
  logic        pad_in_n;
  logic        pad_out;
  logic        pad_oe;
  logic        pad_in_buf_en;
  logic        pad_pullup_en;
  logic        rise_bit = 1'b0;
  logic        fall_bit = 1'b0;
  logic        n_bit = 1'b0;
  logic [31:0] d;
  int          error_cnt = 0;
  int          n_tests = 0;

  always #2 clk = ~clk;
  // 24 ns half period: tile edges never meet a rising clk edge
  always #24 io_clk = ~io_clk;

  dio_tile dut_u (.clk(clk), .resetn(resetn), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .io_clk(io_clk),
    .register_clear(register_clear), .core_out_rise(core_out_rise),
    .core_out_fall(core_out_fall), .core_oe(core_oe),
    .core_out_en(core_out_en), .core_in_en(core_in_en),
    .core_in_rise(core_in_rise), .core_in_fall(core_in_fall),
    .pad_in_p(pad_in_p), .pad_in_n(pad_in_n), .pad_out(pad_out),
    .pad_oe(pad_oe), .pad_in_buf_en(pad_in_buf_en),
    .pad_pullup_en(pad_pullup_en));

  dio_pad_model pad_u (.io_clk(io_clk), .rise_bit(rise_bit),
    .fall_bit(fall_bit), .n_bit(n_bit), .pad_in_p(pad_in_p),
    .pad_in_n(pad_in_n));

  // ****************************************************
  // bus and timing helpers
  // ****************************************************
  task automatic report_and_stop();
    if (error_cnt == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic wr_reg(input logic [3:0] a, input logic [31:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [3:0] a);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask

  // write, then read back with no idle cycle between the strobes
  task automatic wr_rd(input logic [3:0] a, input logic [31:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask

  // control reaches the tile within five tile edges; eight leaves margin
  task automatic set_ctrl(input logic [5:0] c);
    wr_reg(`DIO_ADDR_CTRL, {26'h0, c});
    repeat (8) @(posedge io_clk);
  endtask

  task automatic io_wait(input int n);
    repeat (n) @(posedge io_clk);
    #4;
  endtask

  // ****************************************************
  // scenarios
  // ****************************************************
  task automatic t_power_up();
    `CHK(pad_oe, 1'b0, "oe during clear")
    `CHK(pad_in_buf_en, 1'b0, "buffer during clear")
    `CHK(pad_pullup_en, 1'b1, "pull-up during clear")
    `CHK(pad_out, 1'b0, "pad during clear")
    `CHK(core_in_rise, 1'b0, "input reg during clear")
    rd_reg(`DIO_ADDR_CTRL);
    `CHK(d, 32'h0, "ctrl reset value")
    rd_reg(4'h8);
    `CHK(d, 32'h0, "unmapped read")
    // the clear holds the config sync, so this never reaches the tile
    wr_rd(`DIO_ADDR_CTRL, 32'hffff_ffea);
    `CHK(d, 32'h0000_002a, "ctrl read back")
    wr_reg(`DIO_ADDR_CTRL, 32'h0);
  endtask

  task automatic t_block_oe();
    @(posedge clk);
    core_oe <= 1'b1;
    io_wait(6);
    `CHK(pad_oe, 1'b0, "oe with buffers off")
    `CHK(core_in_rise, 1'b1, "input with buffer off")
  endtask

  task automatic t_sdr_and_clear();
    set_ctrl(6'h01);
    @(posedge clk);
    core_out_rise <= 1'b1;
    io_wait(2);
    `CHK(pad_oe, 1'b1, "oe register")
    `CHK(pad_out, 1'b1, "sdr output register")
    `CHK(core_in_rise, 1'b0, "sdr input register")
    `CHK(pad_pullup_en, 1'b0, "pull-up off with buffer on")
    rd_reg(`DIO_ADDR_STAT);
    `CHK(d[3:1], 3'b110, "status bits")
    register_clear <= 1'b1;
    #2;
    `CHK(pad_oe, 1'b0, "oe async clear")
    `CHK(pad_out, 1'b0, "out async clear")
    io_wait(5);
    register_clear <= 1'b0;
  endtask

  task automatic t_ddr_out();
    set_ctrl(6'h05);
    for (int i = 0; i < 2; i++) begin
      @(posedge clk);
      core_out_rise <= i[0];
      core_out_fall <= ~i[0];
      io_wait(2);
      `CHK(pad_out, i[0], "ddr high phase")
      @(negedge io_clk);
      #4 `CHK(pad_out, ~i[0], "ddr low phase")
    end
  endtask

  task automatic t_ddr_in();
    set_ctrl(6'h03);
    for (int i = 0; i < 2; i++) begin
      @(posedge clk);
      rise_bit <= i[0];
      fall_bit <= ~i[0];
      io_wait(3);
      `CHK(core_in_rise, i[0], "ddr rising bit")
      `CHK(core_in_fall, ~i[0], "ddr falling bit")
      repeat (8) @(posedge clk);
      rd_reg(`DIO_ADDR_STAT);
      `CHK(d[1:0], {i[0], ~i[0]}, "status of ddr bits")
    end
  endtask

  task automatic t_enable_hold();
    set_ctrl(6'h09);
    @(posedge clk);
    rise_bit <= 1'b1;
    fall_bit <= 1'b1;
    core_out_rise <= 1'b1;
    io_wait(3);
    @(posedge clk);
    core_in_en <= 1'b0;
    core_out_en <= 1'b0;
    rise_bit <= 1'b0;
    fall_bit <= 1'b0;
    core_out_rise <= 1'b0;
    io_wait(3);
    `CHK(core_in_rise, 1'b1, "input held")
    `CHK(pad_out, 1'b1, "output held")
    @(posedge clk);
    core_in_en <= 1'b1;
    core_out_en <= 1'b1;
    io_wait(3);
    `CHK(core_in_rise, 1'b0, "input enabled")
    `CHK(pad_out, 1'b0, "output enabled")
  endtask

  task automatic t_diff();
    set_ctrl(6'h31);
    `CHK(pad_pullup_en, 1'b1, "pull-up kept on request")
    for (int i = 0; i < 2; i++) begin
      @(posedge clk);
      rise_bit <= 1'b1;
      fall_bit <= 1'b1;
      n_bit <= i[0];
      io_wait(3);
      `CHK(core_in_rise, ~i[0], "differential capture")
    end
  endtask

  // ****************************************************
  // main sequence and watchdog
  // ****************************************************
  initial begin
    repeat (8) @(posedge clk);
    resetn <= 1'b1;
    // the clear acts at the first tile edge; look once it has landed
    repeat (2) @(posedge io_clk);
    @(posedge clk);
    t_power_up();
    repeat (6) @(posedge io_clk);
    register_clear <= 1'b0;
    t_block_oe();
    t_sdr_and_clear();
    t_ddr_out();
    t_ddr_in();
    t_enable_hold();
    t_diff();
    report_and_stop();
  end

  initial begin
    repeat (50000) @(posedge clk);
    error_cnt++;
    report_and_stop();
  end
endmodule
`default_nettype wire

// ### logic/dio_sync3.sv
// three-stage synchroniser whose output moves once stages two and three agree
`timescale 1ns/1ps
`default_nettype none

module dio_sync3 #(
  parameter int           W    = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  logic [W-1:0] s3_reg;
  logic [W-1:0] agree;

  // s1 feeds s2 only; metastability must not reach the compare
  always_ff @(posedge clk) begin
    if (rst) begin
      s1_reg <= INIT;
      s2_reg <= INIT;
      s3_reg <= INIT;
    end else begin
      s1_reg <= d;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  assign agree = ~(s2_reg ^ s3_reg);

  always_ff @(posedge clk) begin
    if (rst) begin
      q <= INIT;
    end else begin
      q <= (s3_reg & agree) | (q & ~agree);
    end
  end

endmodule

`default_nettype wire

// ### logic/dio_tile.sv
// i/o tile registers: sdr and ddr input and output paths, sdr output-enable path
`timescale 1ns/1ps
`default_nettype none
`include "dio_defs.svh"

module dio_tile #(
  parameter logic PRESET_LEVEL = 1'b0
) (
  input  wire logic                   clk,
  input  wire logic                   resetn,
  input  wire logic [`DIO_ADDR_W-1:0] addr,
  input  wire logic [31:0]            wdata,
  input  wire logic                   wr,
  input  wire logic                   rd,
  output logic      [31:0]            rdata,
  input  wire logic                   io_clk,
  input  wire logic                   register_clear,
  input  wire logic                   core_out_rise,
  input  wire logic                   core_out_fall,
  input  wire logic                   core_oe,
  input  wire logic                   core_out_en,
  input  wire logic                   core_in_en,
  output logic                        core_in_rise,
  output logic                        core_in_fall,
  input  wire logic                   pad_in_p,
  input  wire logic                   pad_in_n,
  output logic                        pad_out,
  output logic                        pad_oe,
  output logic                        pad_in_buf_en,
  output logic                        pad_pullup_en
);

  // ************************************************************
  // register port, core clock domain
  // ************************************************************
  logic [`DIO_CTRL_W-1:0] ctrl_reg;
  logic [`DIO_STAT_W-1:0] stat_clk;
  logic                   rst_clk;

  assign rst_clk = ~resetn;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      ctrl_reg <= `DIO_CTRL_RST;
    end else if (wr && addr == `DIO_ADDR_CTRL) begin
      ctrl_reg <= wdata[`DIO_CTRL_W-1:0];
    end
  end

  // read data stand one cycle only; zero otherwise and for holes
  always_ff @(posedge clk) begin
    if (!resetn) begin
      rdata <= 32'h0000_0000;
    end else if (rd) begin
      unique case (addr)
        `DIO_ADDR_CTRL: rdata <= 32'(ctrl_reg);
        `DIO_ADDR_STAT: rdata <= 32'(stat_clk);
        default:        rdata <= 32'h0000_0000;
      endcase
    end else begin
      rdata <= 32'h0000_0000;
    end
  end

  // ************************************************************
  // crossings
  // ************************************************************
  // per-bit sync only: control is quasi-static, change it while idle
  logic [`DIO_CTRL_W-1:0] cfg_io;
  logic [`DIO_STAT_W-1:0] stat_io;

  dio_sync3 #(
    .W    (`DIO_CTRL_W),
    .INIT (`DIO_CTRL_RST)
  ) u_cfg_sync (
    .clk (io_clk),
    .rst (register_clear),
    .d   (ctrl_reg),
    .q   (cfg_io)
  );

  dio_sync3 #(
    .W    (`DIO_STAT_W),
    .INIT (`DIO_STAT_RST)
  ) u_stat_sync (
    .clk (clk),
    .rst (rst_clk),
    .d   (stat_io),
    .q   (stat_clk)
  );

  // ************************************************************
  // tile registers, i/o clock domain
  // ************************************************************
  logic                 buf_en_cfg;
  logic                 ddr_in_cfg;
  logic                 ddr_out_cfg;
  logic                 use_en_cfg;
  logic                 pull_cfg;
  dio_pkg::dio_path_type path_cfg;
  logic                 en_in;
  logic                 en_out;
  logic                 pad_bit;
  logic                 in2_reg;
  logic                 out_rise_reg;
  logic                 out_fall_reg;

  assign buf_en_cfg  = cfg_io[`DIO_CTRL_BUF_EN];
  assign ddr_in_cfg  = cfg_io[`DIO_CTRL_DDR_IN];
  assign ddr_out_cfg = cfg_io[`DIO_CTRL_DDR_OUT];
  assign use_en_cfg  = cfg_io[`DIO_CTRL_USE_EN];
  assign pull_cfg    = cfg_io[`DIO_CTRL_PULL];
  assign path_cfg    = dio_pkg::dio_path_type'(cfg_io[`DIO_CTRL_DIFF]);

  assign en_in  = !use_en_cfg || core_in_en;
  assign en_out = !use_en_cfg || core_out_en;

  // a disabled input buffer reads as the pull-up level
  assign pad_bit = !pad_in_buf_en ? 1'b1 :
                   (path_cfg == dio_pkg::dio_path_diff) ?
                   (pad_in_p & ~pad_in_n) : pad_in_p;

  // buffer state; the clear returns the pad to its power-up state
  always_ff @(posedge io_clk or posedge register_clear) begin
    if (register_clear) begin
      pad_in_buf_en <= 1'b0;
      pad_pullup_en <= 1'b1;
    end else begin
      pad_in_buf_en <= buf_en_cfg;
      pad_pullup_en <= !buf_en_cfg || pull_cfg;
    end
  end

  // input register 1: rising-edge bit, or the single-rate bit
  always_ff @(posedge io_clk or posedge register_clear) begin
    if (register_clear) begin
      core_in_rise <= PRESET_LEVEL;
    end else if (en_in) begin
      core_in_rise <= pad_bit;
    end
  end

  // input register 2: falling edge, deliberately without clear
  always_ff @(negedge io_clk) begin
    if (ddr_in_cfg) begin
      in2_reg <= pad_bit;
    end
  end

  // input register 3 retimes the falling bit onto the rising edge
  always_ff @(posedge io_clk or posedge register_clear) begin
    if (register_clear) begin
      core_in_fall <= PRESET_LEVEL;
    end else if (ddr_in_cfg && en_in) begin
      core_in_fall <= in2_reg;
    end
  end

  // output and enable registers on the one tile clock
  always_ff @(posedge io_clk or posedge register_clear) begin
    if (register_clear) begin
      out_rise_reg <= PRESET_LEVEL;
      out_fall_reg <= PRESET_LEVEL;
    end else if (en_out) begin
      out_rise_reg <= core_out_rise;
      out_fall_reg <= core_out_fall;
    end
  end

  // the enable is never preset: a driving pad at power-up would fight
  always_ff @(posedge io_clk or posedge register_clear) begin
    if (register_clear) begin
      pad_oe <= 1'b0;
    end else begin
      pad_oe <= buf_en_cfg && core_oe;
    end
  end

  // clock-steered mux: only way to change the pad every half period
  assign pad_out = !ddr_out_cfg ? out_rise_reg :
                   io_clk ? out_rise_reg : out_fall_reg;

  assign stat_io = {pad_oe, pad_in_buf_en, core_in_rise, core_in_fall};

  // ************************************************************
  // assertions
  // ************************************************************
  sequence s_clear_held;
    register_clear [*2];
  endsequence

  property p_clear_state;
    @(posedge io_clk) disable iff (1'b0)
      s_clear_held |-> (!pad_oe && pad_pullup_en && !pad_in_buf_en &&
                        core_in_rise == PRESET_LEVEL &&
                        out_rise_reg == PRESET_LEVEL);
  endproperty
  a_clear_state: assert property (p_clear_state)
    else $error("tile registers not cleared");

  property p_rise_capture;
    @(posedge io_clk) disable iff (register_clear)
      en_in |=> core_in_rise == $past(pad_bit);
  endproperty
  a_rise_capture: assert property (p_rise_capture)
    else $error("rising bit not captured");

  property p_fall_retime;
    @(posedge io_clk) disable iff (register_clear)
      (ddr_in_cfg && en_in) |=> core_in_fall == $past(in2_reg);
  endproperty
  a_fall_retime: assert property (p_fall_retime)
    else $error("falling bit not retimed");

  property p_in_hold;
    @(posedge io_clk) disable iff (register_clear)
      (use_en_cfg && !core_in_en) |=>
        ($stable(core_in_rise) && $stable(core_in_fall));
  endproperty
  a_in_hold: assert property (p_in_hold)
    else $error("input register moved while disabled");

  property p_out_hold;
    @(posedge io_clk) disable iff (register_clear)
      (use_en_cfg && !core_out_en) |=>
        ($stable(out_rise_reg) && $stable(out_fall_reg));
  endproperty
  a_out_hold: assert property (p_out_hold)
    else $error("output register moved while disabled");

  property p_ddr_high;
    @(negedge io_clk) disable iff (register_clear)
      ddr_out_cfg |-> pad_out == out_rise_reg;
  endproperty
  a_ddr_high: assert property (p_ddr_high)
    else $error("pad not first bit in high phase");

  property p_ddr_low;
    @(posedge io_clk) disable iff (register_clear)
      ddr_out_cfg |-> pad_out == out_fall_reg;
  endproperty
  a_ddr_low: assert property (p_ddr_low)
    else $error("pad not second bit in low phase");

  property p_oe_gated;
    @(posedge io_clk) disable iff (register_clear)
      !pad_in_buf_en |-> !pad_oe;
  endproperty
  a_oe_gated: assert property (p_oe_gated)
    else $error("pad driven with buffers disabled");

  property p_ctrl_read;
    @(posedge clk) disable iff (!resetn)
      (wr && addr == `DIO_ADDR_CTRL) ##1 (rd && addr == `DIO_ADDR_CTRL
        && !wr) |=> rdata == 32'($past(wdata[`DIO_CTRL_W-1:0], 2));
  endproperty
  a_ctrl_read: assert property (p_ctrl_read)
    else $error("control read back wrong");

  property p_read_once;
    @(posedge clk) disable iff (!resetn)
      !rd |=> rdata == 32'h0000_0000;
  endproperty
  a_read_once: assert property (p_read_once)
    else $error("read data outside its cycle");

endmodule

`default_nettype wire

// ### shared/dio_defs.svh
// register offsets, field positions and reset values of the i/o tile
`ifndef DIO_DEFS_SVH
`define DIO_DEFS_SVH

`define DIO_ADDR_W        4
`define DIO_ADDR_CTRL     4'h0
`define DIO_ADDR_STAT     4'h4

`define DIO_CTRL_W        6
`define DIO_CTRL_RST      6'h00
`define DIO_CTRL_BUF_EN   0
`define DIO_CTRL_DDR_IN   1
`define DIO_CTRL_DDR_OUT  2
`define DIO_CTRL_USE_EN   3
`define DIO_CTRL_DIFF     4
`define DIO_CTRL_PULL     5

`define DIO_STAT_W        4
`define DIO_STAT_RST      4'h0
`define DIO_STAT_IN_FALL  0
`define DIO_STAT_IN_RISE  1
`define DIO_STAT_BUF_EN   2
`define DIO_STAT_OE       3

`endif

// ### shared/dio_pkg.sv
// types shared by the i/o tile files
`default_nettype none

package dio_pkg;

  typedef enum logic [0:0] {
    dio_path_single = 1'b0,
    dio_path_diff   = 1'b1
  } dio_path_type;

endpackage

`default_nettype wire
